// ===== verilog/olx_regs.vh
`ifndef OLX_REGS_VH
`define OLX_REGS_VH
// Summary of operation
// RULE1: Result is accumulator OR addressed file byte
// RULE2: Destination bit 0 writes the accumulator
// RULE3: Destination bit 1 writes the file
// RULE4: Bank bit 0 selects the access bank
// RULE5: Bank bit 1 uses bank select register
// RULE6: Extended set, access, f<=95: indexed offset
// RULE7: Load twelve-bit literal into selected pointer
// RULE8: Pointer index 0..2 picks one pointer
// RULE9: OR takes one word, one cycle; N,Z
// RULE10: Load takes two cycles: high then low
// ****************************************
// Register map (word indices, byte address is four times)
// ****************************************
`define OLX_ADDR_CTRL    4'h0
`define OLX_ADDR_INSTR   4'h1
`define OLX_ADDR_WREG    4'h2
`define OLX_ADDR_BANK    4'h3
`define OLX_ADDR_FILEDAT 4'h4
`define OLX_ADDR_STATUS  4'h5
`define OLX_ADDR_PTR0    4'h6
`define OLX_ADDR_PTR1    4'h7
`define OLX_ADDR_PTR2    4'h8
`define OLX_ADDR_RESULT  4'h9
`define OLX_ADDR_FADDR   4'ha
// ****************************************
// Instruction fields
// ****************************************
`define OLX_OP_OR        6'h04
`define OLX_OP_LOAD      8'hee
`define OLX_LOAD_SUB     2'h0
`define OLX_D_BIT        9
`define OLX_A_BIT        8
`define OLX_INDEX_MAX    8'h5f
`define OLX_ACCESS_SPLIT 8'h60
`define OLX_ACCESS_HIGH  4'hf
`define OLX_N_BIT        4
`define OLX_Z_BIT        2
`define OLX_STATUS_RST   8'h00
`define OLX_RESP_OKAY    2'b00
`define OLX_RESP_SLVERR  2'b10
`endif

// ===== verilog/olx_alu.v
`timescale 1ns/1ps
module olx_alu (
   input  wire [7:0] acc,
   input  wire [7:0] file_val,
   output wire [7:0] result,
   output wire       neg,
   output wire       zero
);
   assign result = acc | file_val; // see RULE1
   assign neg    = result[7];      // see RULE9
   assign zero   = (result == 8'h00);
endmodule

// ===== verilog/olx_addr.v
`timescale 1ns/1ps
`include "olx_regs.vh"
module olx_addr (
   input  wire [7:0]  f,
   input  wire        bank_bit,
   input  wire        ext_en,
   input  wire [3:0]  bank_select_register,
   input  wire [11:0] pointer2,
   output reg  [11:0] addr,
   output reg         indexed
);
   always @* begin
      indexed = 1'b0;
      if (bank_bit) begin
         addr = {bank_select_register, f};                          // see RULE5
      end else if (ext_en && f <= `OLX_INDEX_MAX) begin
         indexed = 1'b1;
         addr    = pointer2 + {4'h0, f};                            // see RULE6
      end else if (f < `OLX_ACCESS_SPLIT) begin
         addr = {4'h0, f};                                          // see RULE4
      end else begin
         addr = {`OLX_ACCESS_HIGH, f};
      end
   end
endmodule

// ===== verilog/olx_core.v
`timescale 1ns/1ps
`include "olx_regs.vh"
module olx_core (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   // ****************************************
   // Architectural state
   // ****************************************
   reg  [7:0]  acc;
   reg  [3:0]  bank_select_register;
   reg  [7:0]  file_data;
   reg  [7:0]  status;
   reg  [3:0]  pointer_high_byte [0:2];
   reg  [7:0]  pointer_low_byte  [0:2];
   reg  [15:0] instr;
   reg  [15:0] instr2;
   reg         ext_en;
   reg         busy;
   reg  [1:0]  phase;
   reg         second;
   reg  [7:0]  last_result;
   reg  [11:0] last_addr;
   reg         last_indexed;
   // ****************************************
   // Datapath
   // ****************************************
   wire [7:0]  alu_result;
   wire        alu_neg;
   wire        alu_zero;
   wire [11:0] op_addr;
   wire        op_indexed;
   wire [11:0] ptr2 = {pointer_high_byte[2], pointer_low_byte[2]};

   olx_alu u_alu (
      .acc      (acc),
      .file_val (file_data),
      .result   (alu_result),
      .neg      (alu_neg),
      .zero     (alu_zero)
   );

   olx_addr u_addr (
      .f                    (instr[7:0]),
      .bank_bit             (instr[`OLX_A_BIT]),
      .ext_en               (ext_en),
      .bank_select_register (bank_select_register),
      .pointer2             (ptr2),
      .addr                 (op_addr),
      .indexed              (op_indexed)
   );

   function [3:0] reg_index;
      input [31:0] a;
      begin
         reg_index = a[5:2];
      end
   endfunction

   function is_mapped;
      input [31:0] a;
      begin
         is_mapped = (a[31:6] == 26'h0) && (a[5:2] <= `OLX_ADDR_FADDR);
      end
   endfunction

   wire        is_or   = (instr[15:10] == `OLX_OP_OR);
   wire        is_load = (instr[15:8] == `OLX_OP_LOAD) && (instr[7:6] == `OLX_LOAD_SUB)
                         && (instr[5:4] != 2'h3);                   // see RULE8
   wire [1:0]  psel    = instr[5:4];
   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   reg         aw_held;
   reg         w_held;
   reg  [31:0] aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   wire        do_write = aw_held && w_held && !s_axi_bvalid;
   wire [3:0]  widx     = reg_index(aw_addr);
   wire        go       = do_write && is_mapped(aw_addr) && (widx == `OLX_ADDR_CTRL)
                          && w_strb[0] && w_data[0] && !busy;
   integer     i;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready        <= 1'b1;
         s_axi_wready         <= 1'b1;
         s_axi_bvalid         <= 1'b0;
         s_axi_bresp          <= `OLX_RESP_OKAY;
         aw_held              <= 1'b0;
         w_held               <= 1'b0;
         aw_addr              <= 32'h0;
         w_data               <= 32'h0;
         w_strb               <= 4'h0;
         acc                  <= 8'h00;
         bank_select_register <= 4'h0;
         file_data            <= 8'h00;
         status               <= `OLX_STATUS_RST;
         instr                <= 16'h0000;
         instr2               <= 16'h0000;
         ext_en               <= 1'b0;
         busy                 <= 1'b0;
         phase                <= 2'h0;
         second               <= 1'b0;
         last_result          <= 8'h00;
         last_addr            <= 12'h000;
         last_indexed         <= 1'b0;
         for (i = 0; i < 3; i = i + 1) begin
            pointer_high_byte[i] <= 4'h0;
            pointer_low_byte[i]  <= 8'h00;
         end
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         // Writes landing while an instruction runs are dropped to keep state coherent
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? `OLX_RESP_OKAY : `OLX_RESP_SLVERR;
            if (is_mapped(aw_addr) && !busy && w_strb[0]) begin
               case (widx)
                  `OLX_ADDR_CTRL:    ext_en               <= w_data[1];
                  `OLX_ADDR_INSTR: begin
                     instr  <= w_data[15:0];
                     instr2 <= w_data[31:16];
                  end
                  `OLX_ADDR_WREG:    acc                  <= w_data[7:0];
                  `OLX_ADDR_BANK:    bank_select_register <= w_data[3:0];
                  `OLX_ADDR_FILEDAT: file_data            <= w_data[7:0];
                  `OLX_ADDR_STATUS:  status               <= w_data[7:0];
                  default: ;
               endcase
            end
            if (go) begin
               busy   <= 1'b1;
               phase  <= 2'h0;
               second <= 1'b0;
            end
         end
         // ****************************************
         // Quarter-cycle sequencer: decode, read, process, write
         // ****************************************
         if (busy) begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
               if (is_or) begin
                  last_result  <= alu_result;
                  last_addr    <= op_addr;
                  last_indexed <= op_indexed;
                  if (instr[`OLX_D_BIT])
                     file_data <= alu_result;                       // see RULE3
                  else
                     acc <= alu_result;                             // see RULE2
                  status[`OLX_N_BIT] <= alu_neg;                    // see RULE9
                  status[`OLX_Z_BIT] <= alu_zero;
                  busy <= 1'b0;
               end else if (is_load && !second) begin
                  pointer_high_byte[psel] <= instr[3:0];            // see RULE10
                  second <= 1'b1;
               end else if (is_load) begin
                  pointer_low_byte[psel] <= instr2[7:0];            // see RULE7
                  busy <= 1'b0;
               end else begin
                  busy <= 1'b0;
               end
            end
         end
      end
   end
   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   reg [31:0] rd_val;
   always @* begin
      case (reg_index(s_axi_araddr))
         `OLX_ADDR_CTRL:    rd_val = {30'h0, ext_en, busy};
         `OLX_ADDR_INSTR:   rd_val = {instr2, instr};
         `OLX_ADDR_WREG:    rd_val = {24'h0, acc};
         `OLX_ADDR_BANK:    rd_val = {28'h0, bank_select_register};
         `OLX_ADDR_FILEDAT: rd_val = {24'h0, file_data};
         `OLX_ADDR_STATUS:  rd_val = {24'h0, status};
         `OLX_ADDR_PTR0:    rd_val = {20'h0, pointer_high_byte[0], pointer_low_byte[0]};
         `OLX_ADDR_PTR1:    rd_val = {20'h0, pointer_high_byte[1], pointer_low_byte[1]};
         `OLX_ADDR_PTR2:    rd_val = {20'h0, ptr2};
         `OLX_ADDR_RESULT:  rd_val = {24'h0, last_result};
         `OLX_ADDR_FADDR:   rd_val = {19'h0, last_indexed, last_addr};
         default:           rd_val = 32'h0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `OLX_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= is_mapped(s_axi_araddr) ? rd_val : 32'h0;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? `OLX_RESP_OKAY : `OLX_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

// ===== testbench/olx_core_props.sv
`timescale 1ns/1ps
`include "olx_regs.vh"
// ****
// Bus checks
// ****
module olx_props (
   input wire        aclk,
   input wire        aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp lost");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata lost");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open early");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open early");
   a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 32'h2c
      |=> s_axi_rresp == `OLX_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read ok");
   a_good_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < 32'h2c
      |=> s_axi_rresp == `OLX_RESP_OKAY) else $error("good read refused");
   a_bad_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr >= 32'h2c
      |-> ##[1:3] s_axi_bvalid && s_axi_bresp == `OLX_RESP_SLVERR) else $error("bad write ok");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_refused: cover property (s_axi_rvalid && s_axi_rresp == `OLX_RESP_SLVERR);
endmodule
bind olx_core olx_props i_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== testbench/olx_core_tb.sv
`timescale 1ns/1ps
`include "olx_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t: %h %h", $time, g, e); end end
module olx_core_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   int          err_count = 0;
   int          comparisons = 0;
   logic [31:0] rnd = 32'd8942;
   logic [31:0] rdv;
   logic [1:0]  rsp;
   integer      acc, fd, st, bk, f, d, a, x, k, i, t, res, ea;
   integer      ptr [3];
   always #5 aclk = ~aclk;
   olx_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   function automatic [31:0] prng(input [31:0] s);
      repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   // Each transfer starts after an edge, so no signal is driven twice at once
   task automatic wr(input [31:0] ad, input [31:0] dt);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 20 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      // A lost response is a failure, not a silent pass
      if (n == 20) err_count++;
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input [31:0] ad);
      int n;
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 20 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (n == 20) err_count++;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic chk_rd(input [31:0] ad, input [31:0] e);
      rd(ad);
      `CHK(rdv, e)
   endtask
   // Polls busy with a bound so a stuck core still ends the run
   task automatic go(input [31:0] ins);
      int n;
      wr(32'h04, ins);
      wr(32'h00, {30'h0, x[0], 1'b1});
      rdv = 32'h1;
      for (n = 0; n < 30 && rdv[0] !== 1'b0; n++) rd(32'h00);
      `CHK(rdv[0], 1'b0)
      `CHK(rdv[1], x[0])
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      chk_rd(32'h00, 32'h0);
      chk_rd(32'h14, 32'h0);
      x = 0;
      st = 0;
      for (i = 0; i < 3; i++) ptr[i] = 0;
      for (t = 0; t < 8; t++) begin
         rnd = prng(rnd);
         k = (t == 0) ? 32'hfff : rnd[11:0];
         go({8'hf0, k[7:0], 8'hee, 2'b00, t[1:0], k[11:8]});
         if (t % 4 < 3) ptr[t % 4] = k;
         for (i = 0; i < 3; i++) chk_rd(32'h18 + 4 * i, ptr[i]);
         chk_rd(32'h14, st);
      end
      for (t = 0; t < 24; t++) begin
         rnd = prng(rnd);
         acc = (t == 4) ? 0 : rnd[7:0];
         fd = (t == 4) ? 0 : rnd[15:8];
         f = (t < 4) ? (t[0] ? 8'h5f : 8'h60) : rnd[23:16];
         d = rnd[24];
         a = (t < 4) ? 0 : rnd[25];
         x = (t < 4) ? 1 : rnd[26];
         bk = rnd[31:28];
         st = rnd[22:18];
         wr(32'h08, acc);
         wr(32'h10, fd);
         wr(32'h0c, bk);
         wr(32'h14, st);
         go({16'h0, 6'h04, d[0], a[0], f[7:0]});
         res = acc | fd;
         st = (st & 8'heb) | (res[7] ? 16 : 0) | (res == 0 ? 4 : 0);
         if (a) ea = bk * 256 + f;
         else if (x && f <= 8'h5f) ea = 32'h1000 | ((ptr[2] + f) & 32'hfff);
         else ea = (f < 8'h60) ? f : 32'hf00 | f;
         chk_rd(32'h08, d ? acc : res);
         chk_rd(32'h10, d ? res : fd);
         chk_rd(32'h14, st);
         chk_rd(32'h24, res);
         chk_rd(32'h28, ea);
      end
      // Low byte strobe off: write is acknowledged but ignored
      rd(32'h08);
      ea = rdv;
      s_axi_wstrb <= 4'he;
      wr(32'h08, ~ea);
      s_axi_wstrb <= 4'hf;
      chk_rd(32'h08, ea);
      wr(32'h2c, 32'h0);
      `CHK(rsp, `OLX_RESP_SLVERR)
      rd(32'h3c);
      `CHK(rsp, `OLX_RESP_SLVERR)
      tally_and_finish;
   end
   initial begin
      #100000;
      err_count++;
      tally_and_finish;
   end
endmodule
